/* File: sal_pkg.sv */
// Shared constants and types for the converter boundary-scan segment.
package sal_pkg;

	// ****************************************************************
	// Scan segment layout
	// ****************************************************************
	// Field order equals scan order: the last field sits at chain bit 0.
	typedef struct packed {
		logic bandgap_neg_en;
		logic converter_power_en;
		logic amp_power_en;
		logic [9:0] dac_code;
		logic extch_bypass;
		logic gain10_en;
		logic gain20_en;
		logic gnd_neg_en;
		logic hold;
		logic iref_en;
		logic [7:0] pos_input_select;
		logic [2:0] neg_input_select;
		logic gain_pass_gate_en;
		logic latch_precharge_n;
		logic switchcap_test_en;
		logic settle_assist;
		logic supply_ref_select;
	} sal_ctrl_t;

	localparam int CTRL_W = 35;
	localparam int CHAIN_LEN = 36;
	localparam int COMP_POS = 35;

	localparam sal_ctrl_t CTRL_IDLE = '{
		bandgap_neg_en: 1'b0, converter_power_en: 1'b0,
		amp_power_en: 1'b0, dac_code: 10'h200, extch_bypass: 1'b1,
		gain10_en: 1'b0, gain20_en: 1'b0, gnd_neg_en: 1'b0,
		hold: 1'b1, iref_en: 1'b0, pos_input_select: 8'h01,
		neg_input_select: 3'h0, gain_pass_gate_en: 1'b1,
		latch_precharge_n: 1'b1, switchcap_test_en: 1'b0,
		settle_assist: 1'b0, supply_ref_select: 1'b0};

	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam logic [7:0] ADDR_CFG_LO = 8'h00;
	localparam logic [7:0] ADDR_CFG_HI = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam int CFG_HI_W = 3;
	localparam int ST_COMP = 0;
	localparam int ST_BUSY = 1;
	localparam int ST_EXTEST = 2;
	localparam int ST_CNT_LSB = 4;
	localparam int CNT_W = 4;

	typedef enum logic [3:0] {
		REG_CFG_LO = 4'h1,
		REG_CFG_HI = 4'h2,
		REG_STATUS = 4'h4,
		REG_NONE = 4'h8
	} sal_reg_t;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam logic [CNT_W-1:0] DUMMY_COMPARES = 4'ha;
	localparam int ACLK_HALF_CYC = 2;

endpackage

/* File: sal_conv_if.sv */
// Carrier between the scan segment and its dummy-conversion sequencer.
`timescale 1ns/1ps
interface sal_conv_if;
	logic start;
	logic step_en;
	logic busy;
	logic [sal_pkg::CNT_W-1:0] done_cnt;
	modport seq (input start, input step_en, output busy, output done_cnt);
	modport ctl (output start, output step_en, input busy, input done_cnt);
endinterface

/* File: sal_sync.sv */
// Two-flip-flop synchroniser for a group of pin inputs.
`timescale 1ns/1ps
module sal_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Data
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_ff;
	logic [W-1:0] q_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_ff <= '0;
			q_ff <= '0;
		end else begin
			meta_ff <= d;
			q_ff <= meta_ff;
		end
	end
	assign q = q_ff;
endmodule

/* File: sal_dummy_conv.sv */
// Sequencer for the dummy conversion that follows converter power-up.
`timescale 1ns/1ps
module sal_dummy_conv (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Control
	sal_conv_if.seq conv
);
	import sal_pkg::*;

	logic busy_ff;
	logic nxt_busy;
	logic [CNT_W-1:0] cnt_ff;
	logic [CNT_W-1:0] nxt_cnt;

	always_comb begin
		nxt_busy = busy_ff;
		nxt_cnt = cnt_ff;
		if (conv.start) begin
			nxt_busy = 1'b1;
			nxt_cnt = '0;
		end else if (busy_ff && conv.step_en) begin
			nxt_cnt = cnt_ff + 4'h1;
			if (cnt_ff == DUMMY_COMPARES - 4'h1) begin
				nxt_busy = 1'b0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_ff <= 1'b0;
			cnt_ff <= '0;
		end else begin
			busy_ff <= nxt_busy;
			cnt_ff <= nxt_cnt;
		end
	end

	assign conv.busy = busy_ff;
	assign conv.done_cnt = cnt_ff;
endmodule

/* File: sal_scan_adc.sv */
// Converter boundary-scan segment with APB access to its normal settings.
//
// Operation
// - Powering the converter in normal mode starts a ten-comparison dummy conversion.
// - Latch precharge is active low; low tracks the comparator, high holds the latched value.
// - Three-bit field selects the negative input; idle is zero.
// - Switch-cap test routes the x10 stage to channel 4 pin.
// - Supply-reference control picks the supply as reference; idle 0.
// - Pass-gate control enables the gain pass gates; idle 1.
// - Hold samples low, holds high; with the gain stages on it rises with analog clock high.
// - Converter enable set to one powers the converter; idle 0.
`timescale 1ns/1ps
module sal_scan_adc #(
	parameter int ACLK_HALF = sal_pkg::ACLK_HALF_CYC
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Scan link from the TAP controller
	input wire logic tck,
	input wire logic tdi,
	input wire logic tap_capture,
	input wire logic tap_shift,
	input wire logic tap_update,
	input wire logic tap_extest,
	output logic tdo,
	// Converter analog side
	input wire logic comp_in,
	output sal_pkg::sal_ctrl_t adc_ctrl,
	output logic aclk,
	output logic comp_latch,
	output logic chan4_gain_route,
	output logic [2:0] neg_input_onehot,
	output logic conv_busy
);
	import sal_pkg::*;

	// ****************************************************************
	// Address decode
	// ****************************************************************
	function automatic sal_reg_t sal_decode(input logic [7:0] a);
		unique case (a)
			ADDR_CFG_LO: sal_decode = REG_CFG_LO;
			ADDR_CFG_HI: sal_decode = REG_CFG_HI;
			ADDR_STATUS: sal_decode = REG_STATUS;
			default: sal_decode = REG_NONE;
		endcase
	endfunction

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	logic [6:0] pins_s;
	logic tck_s, tdi_s, cap_s, sh_s, upd_s, ext_s, comp_s;

	sal_sync #(.W(7)) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.d({tck, tdi, tap_capture, tap_shift, tap_update, tap_extest,
			comp_in}),
		.q(pins_s)
	);
	assign {tck_s, tdi_s, cap_s, sh_s, upd_s, ext_s, comp_s} = pins_s;

	// ****************************************************************
	// Scan cells
	// ****************************************************************
	// TCK is oversampled, so it must stay well below a quarter of pclk.
	logic tck_prev_ff;
	logic [CHAIN_LEN-1:0] shift_ff, nxt_shift;
	sal_ctrl_t upd_ff, nxt_upd;
	logic tdo_ff, nxt_tdo;
	logic tck_rise, tck_fall;
	sal_ctrl_t adc_ff, nxt_adc;
	logic comp_latch_ff, nxt_comp_latch;

	assign tck_rise = tck_s & ~tck_prev_ff;
	assign tck_fall = ~tck_s & tck_prev_ff;

	always_comb begin
		nxt_shift = shift_ff;
		nxt_upd = upd_ff;
		nxt_tdo = tdo_ff;
		if (tck_rise && cap_s) begin
			// The comparator cell is observe-only and sits at the top.
			nxt_shift = {comp_latch_ff, adc_ff};
		end else if (tck_rise && sh_s) begin
			nxt_shift = {tdi_s, shift_ff[CHAIN_LEN-1:1]};
		end
		if (tck_fall) begin
			nxt_tdo = shift_ff[0];
			if (upd_s) begin
				nxt_upd = shift_ff[CTRL_W-1:0];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tck_prev_ff <= 1'b0;
			shift_ff <= {1'b0, CTRL_IDLE};
			upd_ff <= CTRL_IDLE;
			tdo_ff <= 1'b0;
		end else begin
			tck_prev_ff <= tck_s;
			shift_ff <= nxt_shift;
			upd_ff <= nxt_upd;
			tdo_ff <= nxt_tdo;
		end
	end

	// ****************************************************************
	// Analog clock divider
	// ****************************************************************
	logic [7:0] div_ff, nxt_div;
	logic aclk_ff, nxt_aclk;
	logic aclk_tick;

	assign aclk_tick = (div_ff == 8'(ACLK_HALF - 1));

	always_comb begin
		nxt_div = aclk_tick ? 8'h00 : div_ff + 8'h01;
		nxt_aclk = aclk_tick ? ~aclk_ff : aclk_ff;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_ff <= 8'h00;
			aclk_ff <= 1'b0;
		end else begin
			div_ff <= nxt_div;
			aclk_ff <= nxt_aclk;
		end
	end

	// ****************************************************************
	// Normal-mode settings and APB slave
	// ****************************************************************
	sal_ctrl_t cfg_ff, nxt_cfg;
	logic pready_ff, nxt_pready;
	logic pslverr_ff, nxt_pslverr;
	logic [31:0] prdata_ff, nxt_prdata;
	logic ext_ff;
	sal_reg_t sel;
	logic setup_done;
	logic [31:0] status_word;
	sal_conv_if conv();

	assign sel = sal_decode(paddr);
	assign setup_done = psel & penable & ~pready_ff;

	always_comb begin
		status_word = 32'h0000_0000;
		status_word[ST_COMP] = comp_latch_ff;
		status_word[ST_BUSY] = conv.busy;
		status_word[ST_EXTEST] = ext_ff;
		status_word[ST_CNT_LSB +: CNT_W] = conv.done_cnt;
	end

	always_comb begin
		nxt_cfg = cfg_ff;
		nxt_pready = setup_done;
		nxt_pslverr = setup_done & (sel == REG_NONE);
		nxt_prdata = prdata_ff;
		if (setup_done) begin
			unique case (sel)
				REG_CFG_LO: nxt_prdata = cfg_ff[31:0];
				REG_CFG_HI: nxt_prdata = {29'h0, cfg_ff[CTRL_W-1:32]};
				REG_STATUS: nxt_prdata = status_word;
				REG_NONE: nxt_prdata = 32'h0000_0000;
			endcase
		end
		if (psel && penable && pready_ff && pwrite) begin
			unique case (sel)
				REG_CFG_LO: nxt_cfg[31:0] = pwdata;
				REG_CFG_HI: nxt_cfg[CTRL_W-1:32] = pwdata[CFG_HI_W-1:0];
				REG_STATUS: nxt_cfg = cfg_ff;
				REG_NONE: nxt_cfg = cfg_ff;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_ff <= CTRL_IDLE;
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= 32'h0000_0000;
			ext_ff <= 1'b0;
		end else begin
			cfg_ff <= nxt_cfg;
			pready_ff <= nxt_pready;
			pslverr_ff <= nxt_pslverr;
			prdata_ff <= nxt_prdata;
			ext_ff <= ext_s;
		end
	end

	// ****************************************************************
	// Converter control drive
	// ****************************************************************
	sal_ctrl_t want;
	logic pwr_prev_ff;
	logic [2:0] neg_oh_ff, nxt_neg_oh;
	logic route_ff, nxt_route;

	assign want = ext_ff ? upd_ff : cfg_ff;

	always_comb begin
		nxt_adc = want;
		// A rising hold with gain stages on waits for the analog clock high.
		if (want.hold && !adc_ff.hold && want.amp_power_en &&
				!nxt_aclk) begin
			nxt_adc.hold = 1'b0;
		end
		nxt_comp_latch = comp_latch_ff;
		if (!adc_ff.latch_precharge_n) begin
			nxt_comp_latch = comp_s;
		end
		nxt_route = adc_ff.switchcap_test_en;
		nxt_neg_oh = 3'h0;
		if (adc_ff.neg_input_select != 3'h0) begin
			nxt_neg_oh = 3'h1 << (adc_ff.neg_input_select[1:0]);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			adc_ff <= CTRL_IDLE;
			comp_latch_ff <= 1'b0;
			pwr_prev_ff <= 1'b0;
			route_ff <= 1'b0;
			neg_oh_ff <= 3'h0;
		end else begin
			adc_ff <= nxt_adc;
			comp_latch_ff <= nxt_comp_latch;
			pwr_prev_ff <= adc_ff.converter_power_en;
			route_ff <= nxt_route;
			neg_oh_ff <= nxt_neg_oh;
		end
	end

	// Dummy conversion only in normal mode; scan drives the DAC directly.
	assign conv.start = adc_ff.converter_power_en & ~pwr_prev_ff &
		~ext_ff;
	assign conv.step_en = aclk_tick & aclk_ff;

	sal_dummy_conv u_dummy (
		.pclk(pclk),
		.presetn(presetn),
		.conv(conv)
	);

	logic busy_out_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_out_ff <= 1'b0;
		end else begin
			busy_out_ff <= conv.busy;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign tdo = tdo_ff;
	assign adc_ctrl = adc_ff;
	assign aclk = aclk_ff;
	assign comp_latch = comp_latch_ff;
	assign chan4_gain_route = route_ff;
	assign neg_input_onehot = neg_oh_ff;
	assign conv_busy = busy_out_ff;
endmodule

/* File: sal_scan_adc_monitor.sv */
// Port checker for the converter scan segment.
`timescale 1ns/1ps
module sal_scan_adc_monitor #(
	parameter int ACLK_HALF = 2
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Watched outputs and the extest input
	input wire logic pready,
	input wire logic tap_extest,
	input wire sal_pkg::sal_ctrl_t adc_ctrl,
	input wire logic aclk,
	input wire logic comp_latch,
	input wire logic chan4_gain_route,
	input wire logic [2:0] neg_input_onehot,
	input wire logic conv_busy
);
	import sal_pkg::*;
	// The first compare may come up to one analog clock period late.
	localparam int LEN_LO = 18 * ACLK_HALF + 1;
	localparam int LEN_HI = 20 * ACLK_HALF;
	logic [7:0] len_ff;
	logic [7:0] nxt_len;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	always_comb nxt_len = conv_busy ? len_ff + 8'h01 : 8'h00;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			len_ff <= 8'h00;
		else
			len_ff <= nxt_len;
	end
	sequence s_power_rise;
		$rose(adc_ctrl.converter_power_en) && !tap_extest;
	endsequence
	sequence s_busy_run;
		conv_busy [*8];
	endsequence
	a_idle_reset: assert property (
		$rose(presetn) |-> adc_ctrl == CTRL_IDLE) else $error("not idle");
	a_dummy_start: assert property (
		s_power_rise |-> ##[1:3] s_busy_run) else $error("no dummy run");
	a_dummy_len: assert property (
		$fell(conv_busy) |-> len_ff >= LEN_LO && len_ff <= LEN_HI)
		else $error("dummy length");
	a_latch_freeze: assert property (
		adc_ctrl.latch_precharge_n [*3] |-> $stable(comp_latch))
		else $error("latch moved");
	a_neg_decode: assert property (1'b1 |=> neg_input_onehot ==
		($past(adc_ctrl.neg_input_select) == 3'h0 ? 3'h0 :
		3'h1 << $past(adc_ctrl.neg_input_select[1:0])))
		else $error("neg decode");
	a_chan4_route: assert property (1'b1 |=>
		chan4_gain_route == $past(adc_ctrl.switchcap_test_en))
		else $error("chan4 route");
	a_hold_aclk: assert property (
		$rose(adc_ctrl.hold) && adc_ctrl.amp_power_en |->
		aclk) else $error("hold rise");
	a_pready_pulse: assert property (
		pready |=> !pready) else $error("pready long");
	a_neg_single: assert property (
		$onehot0({adc_ctrl.bandgap_neg_en, adc_ctrl.gnd_neg_en,
		|adc_ctrl.neg_input_select})) else $error("two neg sources");
endmodule

/* File: sal_tester_model.sv */
// Scan tester model driving the link pins of the segment.
`timescale 1ns/1ps
module sal_tester_model (
	// Scan link
	output logic tck,
	output logic tdi,
	output logic tap_capture,
	output logic tap_shift,
	output logic tap_update,
	output logic tap_extest,
	input wire logic tdo
);
	import sal_pkg::*;
	int gap = 2000;
	logic [CHAIN_LEN-1:0] last_o;
	initial begin
		tck = 1'b0;
		tdi = 1'b0;
		tap_capture = 1'b0;
		tap_shift = 1'b0;
		tap_update = 1'b0;
		tap_extest = 1'b0;
		last_o = '0;
	end
	// Output is read mid-high so the slow resync of tdo has settled.
	task automatic tick(output logic o);
		#160 tck = 1'b1;
		#80 o = tdo;
		#80 tck = 1'b0;
	endtask
	task automatic dr_scan(input logic [CHAIN_LEN-1:0] din);
		logic o;
		#(gap) tap_capture = 1'b1;
		tick(o);
		tap_capture = 1'b0;
		tap_shift = 1'b1;
		for (int i = 0; i < CHAIN_LEN; i++) begin
			tdi = din[i];
			tick(o);
			last_o[i] = o;
		end
		tdi = ~tdi;
		tap_shift = 1'b0;
		tap_update = 1'b1;
		tick(o);
		tap_update = 1'b0;
	endtask
	task automatic limit_check(input logic [9:0] code, output logic comp);
		sal_ctrl_t c;
		c = CTRL_IDLE;
		c.converter_power_en = 1'b1;
		// The channel pin's port cells sit outside this segment at zero.
		c.pos_input_select = 8'h08;
		if (!tap_extest)
			dr_scan({1'b0, c});
		// The gap before the next scan covers the power-up wait.
		tap_extest = 1'b1;
		c.hold = 1'b0;
		dr_scan({1'b0, c});
		c.hold = 1'b1;
		dr_scan({1'b0, c});
		c.dac_code = code;
		dr_scan({1'b0, c});
		c.latch_precharge_n = 1'b0;
		dr_scan({1'b0, c});
		c.dac_code = 10'h200;
		c.latch_precharge_n = 1'b1;
		dr_scan({1'b0, c});
		comp = last_o[COMP_POS];
	endtask
endmodule

/* File: tb.sv */
// Self-checking bench for the converter scan segment.
`timescale 1ns/1ps
module tb;
	import sal_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic comp_in = 1'b0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, er, tck, tdi, tdo, tap_extest;
	logic tap_capture, tap_shift, tap_update;
	logic aclk, comp_latch, chan4_gain_route, conv_busy;
	logic [2:0] neg_input_onehot;
	sal_ctrl_t adc_ctrl, cfg;
	int err_count = 0;
	int check_count = 0;
	always #20 pclk = ~pclk;
	// The analog input sits between the two limit codes.
	always @(posedge pclk) comp_in <= adc_ctrl.dac_code > 10'h130;
	sal_scan_adc DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .tck, .tdi, .tap_capture,
		.tap_shift, .tap_update, .tap_extest, .tdo, .comp_in, .adc_ctrl,
		.aclk, .comp_latch, .chan4_gain_route, .neg_input_onehot,
		.conv_busy);
	sal_tester_model tst (.tck, .tdi, .tap_capture, .tap_shift,
		.tap_update, .tap_extest, .tdo);
	task automatic check(input logic [35:0] got, input logic [35:0] exp);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic t_reset();
		check(36'(adc_ctrl), 36'(CTRL_IDLE));
		apb(1'b0, ADDR_CFG_LO, 32'h0);
		check(36'(rd), 36'(CTRL_IDLE[31:0]));
		apb(1'b0, 8'h0c, 32'h0);
		check(36'({er, rd}), 36'h100000000);
	endtask
	task automatic t_normal();
		cfg = CTRL_IDLE;
		cfg.switchcap_test_en = 1'b1;
		cfg.neg_input_select = 3'h2;
		cfg.hold = 1'b0;
		cfg.amp_power_en = 1'b1;
		cfg.converter_power_en = 1'b1;
		apb(1'b1, ADDR_CFG_LO, cfg[31:0]);
		apb(1'b1, ADDR_CFG_HI, {29'h0, cfg[34:32]});
		repeat (3) @(posedge pclk);
		check(36'(adc_ctrl), 36'(cfg));
		check(36'({chan4_gain_route, neg_input_onehot, conv_busy}),
			36'h19);
		cfg.hold = 1'b1;
		cfg.latch_precharge_n = 1'b0;
		apb(1'b1, ADDR_CFG_LO, cfg[31:0]);
		while (conv_busy !== 1'b0) begin
			@(posedge pclk);
		end
		apb(1'b0, ADDR_STATUS, 32'h0);
		check(36'(rd[7:0]), 36'ha1);
		cfg.latch_precharge_n = 1'b1;
		apb(1'b1, ADDR_CFG_LO, cfg[31:0]);
		cfg.dac_code = 10'h100;
		apb(1'b1, ADDR_CFG_LO, cfg[31:0]);
		repeat (8) @(posedge pclk);
		apb(1'b0, ADDR_STATUS, 32'h0);
		check(36'(rd[0]), 36'h1);
	endtask
	task automatic t_scan();
		logic c;
		tst.limit_check(10'h123, c);
		check(36'(c), 36'h0);
		check(36'(tst.last_o[31:22]), 36'h123);
		tst.limit_check(10'h143, c);
		check(36'(c), 36'h1);
		repeat (8) @(posedge pclk);
		check(36'(adc_ctrl.dac_code), 36'h200);
	endtask
	task automatic test_done();
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset();
		t_normal();
		t_scan();
		test_done();
	end
	initial begin
		#1000000;
		err_count++;
		test_done();
	end
endmodule
bind sal_scan_adc sal_scan_adc_monitor #(.ACLK_HALF(ACLK_HALF)) u_mon (
	.pclk, .presetn, .pready, .tap_extest, .adc_ctrl, .aclk, .comp_latch,
	.chan4_gain_route, .neg_input_onehot, .conv_busy);
